/* verilog/ulb_consts.svh */
// register map, field positions, reset values and counts of the lin uart
`ifndef ULB_CONSTS_SVH
`define ULB_CONSTS_SVH

// byte addresses of the register words
`define ULB_ADDR_BAUD   8'h00
`define ULB_ADDR_TXCTL  8'h04
`define ULB_ADDR_RXSTAT 8'h08
`define ULB_ADDR_DIVLO  8'h0C
`define ULB_ADDR_DIVHI  8'h10
`define ULB_ADDR_RXDATA 8'h14
`define ULB_ADDR_TXDATA 8'h18

// baud_control bits
`define ULB_BIT_AUTOBAUD 0
`define ULB_BIT_WAKE     1
`define ULB_BIT_WIDE     2
`define ULB_BIT_HSPEED   3
`define ULB_BIT_OVF      4
`define ULB_BIT_RXIDLE   5
// transmit_control bits
`define ULB_BIT_TRANSMIT_ENABLE     0
`define ULB_BIT_SENDBRK  1
`define ULB_BIT_SHEMPTY  2
`define ULB_BIT_TXFLAG   3
// receive status bits
`define ULB_BIT_RXFLAG   0
`define ULB_BIT_FRAMERR  1

// reset values
`define ULB_DIV_RESET    16'h0000
`define ULB_BYTE_RESET   8'h00

// prescale and count figures
`define ULB_PRE_FAST     6'h04
`define ULB_PRE_MID      6'h10
`define ULB_PRE_SLOW     6'h3F
`define ULB_PRE_SLOW_ADD 1
`define ULB_AB_SUB_LAST  3'h7
`define ULB_AB_RISES     3'h4
`define ULB_AB_START     16'h0001
`define ULB_CHAR_BITS    4'hA
`define ULB_BREAK_BITS   4'hE

// axi responses
`define ULB_RESP_OKAY    2'h0
`define ULB_RESP_SLVERR  2'h2

`endif

/* verilog/ulb_pkg.sv */
// types shared by the lin uart modules
package ulb_pkg;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } ulb_rx_t;

    typedef enum logic [1:0] {
        AB_OFF   = 2'b00,
        AB_FALL  = 2'b01,
        AB_RISE1 = 2'b10,
        AB_COUNT = 2'b11
    } ulb_ab_t;

    typedef struct packed {
        logic [13:0] shift;
        logic [3:0]  left;
        logic        busy;
        logic        isBreak;
        logic        line;
        logic        breakDone;
    } ulb_tx_state_t;

endpackage

/* verilog/ulb_tx_shift.sv */
// serialiser for data characters and break characters
`timescale 1ns/1ps
`include "ulb_consts.svh"
module ulb_tx_shift
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       srst,
    // bit timing and load
    input  wire logic       bitTick,
    input  wire logic       load,
    input  wire logic       loadBreak,
    input  wire logic [7:0] loadData,
    // line and status
    output logic            transmitLine,
    output logic            busy,
    output logic            breakDone
);
    ulb_pkg::ulb_tx_state_t s;
    ulb_pkg::ulb_tx_state_t next_s;

    // frame built lsb first; a break is all zero between start and stop
    always_comb
    begin
        next_s = s;
        next_s.breakDone = 1'b0;
        if (load && !s.busy)
        begin
            next_s.busy    = 1'b1;
            next_s.isBreak = loadBreak;
            if (loadBreak)
            begin
                next_s.shift = 14'h2000;
                next_s.left  = `ULB_BREAK_BITS;
            end
            else
            begin
                next_s.shift = {4'h0, 1'b1, loadData, 1'b0};
                next_s.left  = `ULB_CHAR_BITS;
            end
        end
        else if (s.busy && bitTick)
        begin
            if (s.left == 4'h0)
            begin
                // stop bit served its full period
                next_s.busy      = 1'b0;
                next_s.line      = 1'b1;
                next_s.breakDone = s.isBreak;
            end
            else
            begin
                next_s.line  = s.shift[0];
                next_s.shift = {1'b0, s.shift[13:1]};
                next_s.left  = s.left - 4'h1;
            end
        end
    end

    // state register
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            s      <= '0;
            s.line <= 1'b1;
        end
        else
            s <= next_s;
    end

    assign transmitLine = s.line;
    assign busy         = s.busy;
    assign breakDone    = s.breakDone;
endmodule // ulb_tx_shift

/* verilog/ulb_lin_uart.sv */
// lin uart extensions: auto-baud, wake on break, break send and receive
`timescale 1ns/1ps
`include "ulb_consts.svh"
module ulb_lin_uart
#(
    parameter int ADDR_W = 8
)
(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              srst,
    // axi4-lite write address and data
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // axi4-lite write response
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // serial line
    input  wire logic              receiveLine,
    output logic                   transmitLine
);
    // offsets need eight address bits
    if (ADDR_W < 8)
    begin : g_chk
        $error("ulb_lin_uart: ADDR_W below 8");
    end

    typedef struct packed {
        logic              axiWr;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
        logic              rxMeta;
        logic              rxSync;
        logic              rxPrev;
        logic [5:0]        preCnt;
        logic [2:0]        abSub;
        logic [2:0]        abRises;
        ulb_pkg::ulb_ab_t  abState;
        logic              autobaudEnable;
        logic              wakeEnable;
        logic              wideSelect;
        logic              highSpeedSelect;
        logic              overflowFlag;
        logic              transmitEnable;
        logic              sendBreakRequest;
        logic [15:0]       divisor;
        ulb_pkg::ulb_rx_t  rxState;
        logic [15:0]       rxCnt;
        logic [2:0]        rxBit;
        logic [7:0]        rxShift;
        logic [7:0]        receiveHolding;
        logic              framingError;
        logic              receiveFlag;
        logic [15:0]       txCnt;
        logic [7:0]        transmitHolding;
        logic              holdFull;
        logic              holdBreak;
        logic              breakActive;
    } ulb_state_t;

    ulb_state_t s;
    ulb_state_t next_s;

    logic rise;
    logic fall;
    logic baseTick;
    logic bitTick;
    logic txLoad;
    logic txBusy;
    logic txBreakDone;
    logic wrGo;
    logic rdGo;

    // base clock divide from the two selects
    function automatic logic [5:0] baseLast(input logic w, input logic h);
        unique case ({w, h})
            2'b11:   baseLast = `ULB_PRE_FAST - 6'h01;
            2'b00:   baseLast = `ULB_PRE_SLOW;
            default: baseLast = `ULB_PRE_MID - 6'h01;
        endcase
    endfunction

    // bit period in base ticks minus one; narrow mode ignores high byte
    function automatic logic [15:0] bitLast(input ulb_state_t st);
        bitLast = st.wideSelect ? st.divisor : {8'h00, st.divisor[7:0]};
    endfunction

    // register read mux
    function automatic logic [31:0] regRead(input logic [7:0] a,
                                            input ulb_state_t st);
        regRead = 32'h0000_0000;
        unique case (a)
            `ULB_ADDR_BAUD:
            begin
                regRead[`ULB_BIT_AUTOBAUD] = st.autobaudEnable;
                regRead[`ULB_BIT_WAKE]     = st.wakeEnable;
                regRead[`ULB_BIT_WIDE]     = st.wideSelect;
                regRead[`ULB_BIT_HSPEED]   = st.highSpeedSelect;
                regRead[`ULB_BIT_OVF]      = st.overflowFlag;
                regRead[`ULB_BIT_RXIDLE]   = st.rxState == ulb_pkg::RX_IDLE;
            end
            `ULB_ADDR_TXCTL:
            begin
                regRead[`ULB_BIT_TRANSMIT_ENABLE]    = st.transmitEnable;
                regRead[`ULB_BIT_SENDBRK] = st.sendBreakRequest;
                regRead[`ULB_BIT_SHEMPTY] = !txBusy;
                regRead[`ULB_BIT_TXFLAG]  = !st.holdFull;
            end
            `ULB_ADDR_RXSTAT:
            begin
                regRead[`ULB_BIT_RXFLAG]  = st.receiveFlag;
                regRead[`ULB_BIT_FRAMERR] = st.framingError;
            end
            `ULB_ADDR_DIVLO:  regRead[7:0] = st.divisor[7:0];
            `ULB_ADDR_DIVHI:  regRead[7:0] = st.divisor[15:8];
            `ULB_ADDR_RXDATA: regRead[7:0] = st.receiveHolding;
            default:          regRead = 32'h0000_0000;
        endcase
    endfunction

    // known address check, shared by both channels
    function automatic logic mapped(input logic [7:0] a);
        mapped = a == `ULB_ADDR_BAUD  || a == `ULB_ADDR_TXCTL  ||
                 a == `ULB_ADDR_RXSTAT || a == `ULB_ADDR_DIVLO ||
                 a == `ULB_ADDR_DIVHI || a == `ULB_ADDR_RXDATA ||
                 a == `ULB_ADDR_TXDATA;
    endfunction

    // edges seen only on the second synchroniser stage
    assign rise     = s.rxSync && !s.rxPrev;
    assign fall     = !s.rxSync && s.rxPrev;
    assign baseTick = s.preCnt == baseLast(s.wideSelect, s.highSpeedSelect);
    assign bitTick  = baseTick && s.txCnt >= bitLast(s);
    assign txLoad   = s.holdFull && !txBusy && s.transmitEnable;
    assign wrGo     = s.axiWr && awvalid && wvalid;
    assign rdGo     = s.arready && arvalid;

    always_comb
    begin
        next_s = s;

        // two-stage receive synchroniser
        next_s.rxMeta = receiveLine;
        next_s.rxSync = s.rxMeta;
        next_s.rxPrev = s.rxSync;

        // prescaler; runs on to 63 and wraps there if selects change below the count
        if (baseTick || s.preCnt > `ULB_PRE_SLOW - 6'h01)
            next_s.preCnt = 6'h00;
        else
            next_s.preCnt = s.preCnt + 6'h01;

        // axi write channel: both halves taken in one cycle
        next_s.axiWr = awvalid && wvalid && !s.axiWr && !s.bvalid;
        if (s.bvalid && bready)
            next_s.bvalid = 1'b0;
        if (wrGo)
        begin
            next_s.bvalid = 1'b1;
            next_s.bresp  = mapped(awaddr[7:0]) ? `ULB_RESP_OKAY
                                                : `ULB_RESP_SLVERR;
        end
        if (wrGo && wstrb[0])
        begin
            unique case (awaddr[7:0])
                `ULB_ADDR_BAUD:
                begin
                    next_s.autobaudEnable  = wdata[`ULB_BIT_AUTOBAUD];
                    next_s.wakeEnable      = wdata[`ULB_BIT_WAKE];
                    next_s.wideSelect      = wdata[`ULB_BIT_WIDE];
                    next_s.highSpeedSelect = wdata[`ULB_BIT_HSPEED];
                    // clear only once enable was already low
                    if (!wdata[`ULB_BIT_OVF] && !s.autobaudEnable)
                        next_s.overflowFlag = 1'b0;
                end
                `ULB_ADDR_TXCTL:
                begin
                    next_s.transmitEnable   = wdata[`ULB_BIT_TRANSMIT_ENABLE];
                    next_s.sendBreakRequest = wdata[`ULB_BIT_SENDBRK];
                end
                `ULB_ADDR_DIVLO: next_s.divisor[7:0]  = wdata[7:0];
                `ULB_ADDR_DIVHI: next_s.divisor[15:8] = wdata[7:0];
                `ULB_ADDR_TXDATA:
                    if (s.transmitEnable && !s.holdFull)
                    begin
                        next_s.holdFull        = 1'b1;
                        next_s.transmitHolding = wdata[7:0];
                        // one break per request; later bytes are data
                        next_s.holdBreak = s.sendBreakRequest &&
                            !s.holdBreak && !s.breakActive;
                    end
                default: ;
            endcase
        end

        // axi read channel
        next_s.arready = arvalid && !s.arready && !s.rvalid;
        if (s.rvalid && rready)
            next_s.rvalid = 1'b0;
        if (rdGo)
        begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = regRead(araddr[7:0], s);
            next_s.rresp  = mapped(araddr[7:0]) ? `ULB_RESP_OKAY
                                                : `ULB_RESP_SLVERR;
            if (araddr[7:0] == `ULB_ADDR_RXDATA)
                next_s.receiveFlag = 1'b0;
        end

        // transmit bit timer and holding register
        if (baseTick)
            next_s.txCnt = bitTick ? 16'h0000 : s.txCnt + 16'h0001;
        if (txLoad)
        begin
            next_s.holdFull    = 1'b0;
            next_s.holdBreak   = 1'b0;
            next_s.breakActive = s.holdBreak;
        end
        if (txBreakDone)
        begin
            next_s.breakActive      = 1'b0;
            next_s.sendBreakRequest = 1'b0;
        end

        // receiver: held idle while calibrating or watching for wake
        if (s.autobaudEnable || s.wakeEnable)
            next_s.rxState = ulb_pkg::RX_IDLE;
        else
        begin
            if (baseTick)
                next_s.rxCnt = s.rxCnt + 16'h0001;
            unique case (s.rxState)
                ulb_pkg::RX_IDLE:
                    if (fall)
                    begin
                        next_s.rxState = ulb_pkg::RX_START;
                        next_s.rxCnt   = 16'h0000;
                    end
                ulb_pkg::RX_START:
                    if (baseTick && s.rxCnt >= (bitLast(s) >> 1))
                    begin
                        // false start if the line went back high
                        next_s.rxState = s.rxSync ? ulb_pkg::RX_IDLE
                                                  : ulb_pkg::RX_DATA;
                        next_s.rxCnt   = 16'h0000;
                        next_s.rxBit   = 3'h0;
                    end
                ulb_pkg::RX_DATA:
                    if (baseTick && s.rxCnt >= bitLast(s))
                    begin
                        next_s.rxShift = {s.rxSync, s.rxShift[7:1]};
                        next_s.rxCnt   = 16'h0000;
                        next_s.rxBit   = s.rxBit + 3'h1;
                        if (s.rxBit == 3'h7)
                            next_s.rxState = ulb_pkg::RX_STOP;
                    end
                ulb_pkg::RX_STOP:
                    if (baseTick && s.rxCnt >= bitLast(s))
                    begin
                        // break: zero data, low stop, flag in one edge
                        next_s.receiveHolding = s.rxShift;
                        next_s.framingError   = !s.rxSync;
                        next_s.receiveFlag    = 1'b1;
                        next_s.rxState        = ulb_pkg::RX_IDLE;
                    end
            endcase
        end

        // wake on break: first fall is the wake, the rise ends it
        if (s.wakeEnable)
        begin
            if (fall)
                next_s.receiveFlag = 1'b1;
            if (rise)
                next_s.wakeEnable = 1'b0;
        end

        // auto-baud sequencer; waits while wake is still armed
        if (!s.autobaudEnable)
            next_s.abState = ulb_pkg::AB_OFF;
        else
        begin
            unique case (s.abState)
                ulb_pkg::AB_OFF:
                    if (!s.wakeEnable)
                        next_s.abState = ulb_pkg::AB_FALL;
                ulb_pkg::AB_FALL:
                    if (fall && !s.wakeEnable)
                        next_s.abState = ulb_pkg::AB_RISE1;
                ulb_pkg::AB_RISE1:
                    if (rise)
                    begin
                        next_s.abState = ulb_pkg::AB_COUNT;
                        next_s.divisor = `ULB_AB_START;
                        next_s.abSub   = 3'h0;
                        next_s.abRises = 3'h1;
                    end
                ulb_pkg::AB_COUNT:
                begin
                    // full 16 bits count whatever the width select
                    if (baseTick)
                    begin
                        next_s.abSub = s.abSub + 3'h1;
                        if (s.abSub == `ULB_AB_SUB_LAST)
                        begin
                            next_s.divisor = s.divisor + 16'h0001;
                            if (s.divisor == 16'hFFFF)
                                next_s.overflowFlag = 1'b1;
                        end
                    end
                    if (rise)
                    begin
                        next_s.abRises = s.abRises + 3'h1;
                        if (s.abRises == `ULB_AB_RISES)
                        begin
                            // fifth rise: result stands in the divisor
                            next_s.abState        = ulb_pkg::AB_OFF;
                            next_s.autobaudEnable = 1'b0;
                            next_s.receiveFlag    = 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // single state register
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            s                <= '0;
            s.rxMeta         <= 1'b1;
            s.rxSync         <= 1'b1;
            s.rxPrev         <= 1'b1;
            s.divisor        <= `ULB_DIV_RESET;
            s.receiveHolding <= `ULB_BYTE_RESET;
            s.abState        <= ulb_pkg::AB_OFF;
            s.rxState        <= ulb_pkg::RX_IDLE;
        end
        else
            s <= next_s;
    end

    // character and break serialiser
    ulb_tx_shift u_shift
    (
        .mclk         (mclk),
        .srst         (srst),
        .bitTick      (bitTick),
        .load         (txLoad),
        .loadBreak    (s.holdBreak),
        .loadData     (s.transmitHolding),
        .transmitLine (transmitLine),
        .busy         (txBusy),
        .breakDone    (txBreakDone)
    );

    assign awready = s.axiWr;
    assign wready  = s.axiWr;
    assign bvalid  = s.bvalid;
    assign bresp   = s.bresp;
    assign arready = s.arready;
    assign rvalid  = s.rvalid;
    assign rdata   = s.rdata;
    assign rresp   = s.rresp;
endmodule // ulb_lin_uart

/* tb/ulb_lin_uart_monitor.sv */
// port checker for the lin uart register bus
`timescale 1ns/1ps
module ulb_lin_uart_monitor
#(
    parameter int ADDR_W = 8
)
(
    // clock and reset
    input wire logic        mclk,
    input wire logic        srst,
    // bus handshake
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic [1:0]  bresp,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // a transfer taken on each side
    sequence wrTaken;
        awvalid && awready;
    endsequence
    sequence rdTaken;
        arvalid && arready;
    endsequence
    write_answer_a: assert property (wrTaken |=> bvalid && !awready)
        else $error("write not answered next cycle");
    read_answer_a: assert property (rdTaken |=> rvalid && !arready)
        else $error("read not answered next cycle");
    ready_pulse_a: assert property (awready |=> !awready)
        else $error("write ready longer than one cycle");
    wready_pair_a: assert property (wready == awready)
        else $error("write halves readied apart");
    bresp_hold_a: assert property (bvalid && !bready |=>
        bvalid && $stable(bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (rvalid && !rready |=>
        rvalid && $stable(rdata))
        else $error("read data dropped early");
    read_refused_a: assert property (rvalid |-> !arready)
        else $error("read accepted while answer pending");
    write_refused_a: assert property (bvalid |-> !awready)
        else $error("write accepted while answer pending");
    bvalid_cause_a: assert property ($rose(bvalid) |->
        $past(awvalid && awready))
        else $error("write answer without transfer");
    rdata_upper_a: assert property (rvalid |-> rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
endmodule // ulb_lin_uart_monitor

bind ulb_lin_uart ulb_lin_uart_monitor #(.ADDR_W(ADDR_W)) mon
(
    .mclk(mclk), .srst(srst), .awvalid(awvalid), .awready(awready),
    .wready(wready),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata)
);

/* tb/ulb_remote_node.sv */
// remote serial node: drives the receive pin, samples the transmit pin
`timescale 1ns/1ps
module ulb_remote_node
(
    // clock
    input  wire logic mclk,
    // serial pins
    output logic      toDevice,
    input  wire logic fromDevice
);
    initial toDevice = 1'b1;
    // frame lsb first, then idle high for two bit times
    task automatic sendFrame(input logic [13:0] f, input int n, input int bt);
        for (int i = 0; i < n; i++)
        begin
            toDevice <= f[i];
            repeat (bt) @(posedge mclk);
        end
        toDevice <= 1'b1;
        repeat (2 * bt) @(posedge mclk);
    endtask
    // sample mid-bit; stop after the last sample so the next start is seen
    task automatic recvFrame(input int n, input int bt, output logic [13:0] f);
        f = 14'h0000;
        do @(posedge mclk); while (fromDevice !== 1'b0);
        repeat (bt / 2) @(posedge mclk);
        for (int i = 0; i < n; i++)
        begin
            f[i] = fromDevice;
            if (i < n - 1) repeat (bt) @(posedge mclk);
        end
    endtask
endmodule // ulb_remote_node

/* tb/testbench.sv */
// self-checking bench for the lin uart extensions
`timescale 1ns/1ps
`include "ulb_consts.svh"
module testbench;
    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0]  wstrb = 4'hF;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, rxLine, txLine;
    logic [1:0]  bresp, rresp, resp;
    logic [13:0] bits;
    int          nMismatch = 0, comparisons = 0;

    always #2.5 mclk = ~mclk;
    ulb_lin_uart uut (.mclk(mclk), .srst(srst), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .receiveLine(rxLine), .transmitLine(txLine));
    ulb_remote_node node (.mclk(mclk), .toDevice(rxLine),
        .fromDevice(txLine));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            nMismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // bus write; valids held until taken, bready until the answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge mclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge mclk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
        @(posedge mclk);
    endtask
    // bus read, masked compare of the data
    task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge mclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge mclk); while (rvalid !== 1'b1);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge mclk);
        chk(rd & m, e);
    endtask
    task automatic resetScan();
        rdc(`ULB_ADDR_DIVLO, 32'hFF, 32'h00);
        chk({30'h0, resp}, 32'h0);
        rdc(`ULB_ADDR_TXCTL, 32'h0F, 32'h0C);
        rdc(8'h1C, 32'hFF, 32'h00);
        chk({30'h0, resp}, 32'h2);
        wr(8'h1C, 32'hFF);
        chk({30'h0, resp}, 32'h2);
    endtask
    // one select set, 4096-cycle bits: count 1 + 8*4096/128 = 257
    task automatic autoBaud();
        wr(`ULB_ADDR_BAUD, 32'h09);
        chk({30'h0, resp}, 32'h0);
        node.sendFrame(14'h02AA, 10, 4096);
        rdc(`ULB_ADDR_BAUD, 32'h11, 32'h00);
        rdc(`ULB_ADDR_RXSTAT, 32'h01, 32'h01);
        rdc(`ULB_ADDR_DIVHI, 32'hFF, 32'h01);
        rdc(`ULB_ADDR_DIVLO, 32'hFF, 32'h01);
        rdc(`ULB_ADDR_RXDATA, 32'hFF, 32'h00);
        rdc(`ULB_ADDR_RXSTAT, 32'h01, 32'h00);
    endtask
    // divisor 3 with both selects: 16 cycles a bit
    task automatic wake();
        wr(`ULB_ADDR_DIVLO, 32'h03);
        wr(`ULB_ADDR_DIVHI, 32'h00);
        rdc(`ULB_ADDR_BAUD, 32'h20, 32'h20);
        wr(`ULB_ADDR_BAUD, 32'h0E);
        fork
            node.sendFrame(14'h2000, 14, 16);
            begin
                repeat (60) @(posedge mclk);
                rdc(`ULB_ADDR_RXSTAT, 32'h03, 32'h01);
                rdc(`ULB_ADDR_BAUD, 32'h02, 32'h02);
            end
        join
        rdc(`ULB_ADDR_BAUD, 32'h02, 32'h00);
        rdc(`ULB_ADDR_RXDATA, 32'hFF, 32'h00);
        rdc(`ULB_ADDR_RXSTAT, 32'h03, 32'h00);
    endtask
    task automatic rxBreak();
        node.sendFrame(14'h2000, 14, 16);
        rdc(`ULB_ADDR_RXSTAT, 32'h03, 32'h03);
        rdc(`ULB_ADDR_RXDATA, 32'hFF, 32'h00);
        node.sendFrame(14'h034A, 10, 16);
        rdc(`ULB_ADDR_RXSTAT, 32'h03, 32'h01);
        rdc(`ULB_ADDR_RXDATA, 32'hFF, 32'hA5);
    endtask
    task automatic txBreak();
        wr(`ULB_ADDR_TXCTL, 32'h03);
        fork
            begin
                node.recvFrame(14, 16, bits);
                chk({18'h0, bits}, 32'h2000);
                node.recvFrame(10, 16, bits);
                chk({18'h0, bits}, 32'h02AA);
            end
            begin
                wr(`ULB_ADDR_TXDATA, 32'hFF);
                repeat (40) @(posedge mclk);
                rdc(`ULB_ADDR_TXCTL, 32'h0A, 32'h0A);
                wr(`ULB_ADDR_TXDATA, 32'h55);
            end
        join
        repeat (20) @(posedge mclk);
        rdc(`ULB_ADDR_TXCTL, 32'h02, 32'h00);
    endtask
    task automatic reportAndStop();
        if (nMismatch == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // main sequence after a four-cycle reset
    initial
    begin
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        resetScan();
        autoBaud();
        wake();
        rxBreak();
        txBreak();
        reportAndStop();
    end
    // watchdog: the tests need about 50000 cycles
    initial
    begin
        repeat (90000) @(posedge mclk);
        nMismatch++;
        reportAndStop();
    end
endmodule // testbench
